//--- shared/fsc_pkg.sv
// Package for the flash erase and status controller.
// Assumes a 200 MHz system clock and a x16 parallel NOR flash on the pins.
package fsc_pkg;

	// ----------------------------------------
	// Widths and clock
	// ----------------------------------------
	localparam int FL_ADDR_W = 22;
	localparam int FL_DATA_W = 16;
	localparam int SW_ADDR_W = 8;
	localparam int CLK_PERIOD_NS = 5;

	// ----------------------------------------
	// Times and derived cycle counts
	// ----------------------------------------
	localparam int T_SUSPEND_NS = 20000;
	localparam int SUSPEND_CYC = T_SUSPEND_NS / CLK_PERIOD_NS;
	localparam int T_RESUME_GAP_US = 200;
	localparam int RESUME_GAP_CYC = (T_RESUME_GAP_US * 1000) / CLK_PERIOD_NS;
	localparam int T_SETTLE_NS = 1000;
	localparam int SETTLE_CYC = (T_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int T_ABORT_NS = 200;
	localparam int ABORT_CYC = (T_ABORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int T_PULSE_NS = 40;
	localparam int PULSE_CYC = (T_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SYNC_DEPTH = 2;

	// ----------------------------------------
	// Software register offsets
	// ----------------------------------------
	localparam logic [SW_ADDR_W-1:0] REG_CTRL = 8'h00;
	localparam logic [SW_ADDR_W-1:0] REG_CMD = 8'h04;
	localparam logic [SW_ADDR_W-1:0] REG_ADDR = 8'h08;
	localparam logic [SW_ADDR_W-1:0] REG_WDATA = 8'h0C;
	localparam logic [SW_ADDR_W-1:0] REG_STATUS = 8'h10;
	localparam logic [SW_ADDR_W-1:0] REG_RDATA = 8'h14;

	// CTRL fields
	localparam int CTRL_WP_N = 0;
	localparam int CTRL_RST_N = 1;
	localparam int CTRL_BYPASS = 2;
	localparam int CTRL_SECT_ERASE = 3;
	localparam int CTRL_W = 4;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 4'h3;

	// Commands written to REG_CMD
	localparam logic [3:0] OP_READ = 4'h1;
	localparam logic [3:0] OP_WRITE = 4'h2;
	localparam logic [3:0] OP_SUSPEND = 4'h3;
	localparam logic [3:0] OP_RESUME = 4'h4;
	localparam logic [3:0] OP_CHIP_ERASE = 4'h5;
	localparam logic [3:0] OP_POLL = 4'h6;
	localparam logic [3:0] OP_CLR_ABORT = 4'h7;

	// ----------------------------------------
	// Flash bus codes and status bit positions
	// ----------------------------------------
	localparam logic [FL_DATA_W-1:0] CODE_SUSPEND = 16'h00B0;
	localparam logic [FL_DATA_W-1:0] CODE_RESUME = 16'h0030;
	localparam logic [FL_DATA_W-1:0] CODE_CHIP_ERASE = 16'h0010;
	localparam logic [FL_DATA_W-1:0] CODE_UNLOCK1 = 16'h00AA;
	localparam logic [FL_DATA_W-1:0] CODE_UNLOCK2 = 16'h0055;
	localparam logic [FL_DATA_W-1:0] CODE_ERASE_SETUP = 16'h0080;
	localparam logic [FL_ADDR_W-1:0] ADDR_UNLOCK1 = 22'h000555;
	localparam logic [FL_ADDR_W-1:0] ADDR_UNLOCK2 = 22'h0002AA;
	localparam logic [2:0] CHIP_ERASE_LAST = 3'h5;
	localparam int SECT_LSB = 12;
	localparam int BIT_POLLING = 7;
	localparam int BIT_PRIMARY_TOGGLE = 6;
	localparam int BIT_SECONDARY_TOGGLE = 2;
	localparam int BIT_BUFFER_ABORT = 1;

	// Status register fields
	localparam int ST_BUSY = 0;
	localparam int ST_SUSPENDED = 1;
	localparam int ST_CHIP_ERASING = 2;
	localparam int ST_ABORT_SEEN = 3;
	localparam int ST_REFUSED = 4;
	localparam int ST_READY_BUSY_N = 5;
	localparam int ST_RESUME_GAP = 6;
	localparam int ST_SEC_TOGGLE = 7;
	localparam int ST_POLLING = 8;

endpackage

//--- hdl/fsc_bus.sv
// One asynchronous flash bus cycle: a write strobe or an output-enable read.
// Assumes the flash data pins come from outside the clock domain.
`timescale 1ns/1ps
module fsc_bus #(
	parameter int PULSE = fsc_pkg::PULSE_CYC
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_start,
	input wire logic i_write,
	input wire logic [fsc_pkg::FL_ADDR_W-1:0] i_addr,
	input wire logic [fsc_pkg::FL_DATA_W-1:0] i_wdata,
	input wire logic [fsc_pkg::FL_DATA_W-1:0] i_dq,
	output logic o_done,
	output logic [fsc_pkg::FL_DATA_W-1:0] o_rdata,
	output logic o_ce_n,
	output logic o_we_n,
	output logic o_oe_n,
	output logic [fsc_pkg::FL_ADDR_W-1:0] o_addr,
	output logic [fsc_pkg::FL_DATA_W-1:0] o_dq,
	output logic o_dq_oe
);
	import fsc_pkg::*;

	typedef enum logic [3:0] {
		B_IDLE = 4'h1,
		B_SETUP = 4'h2,
		B_PULSE = 4'h4,
		B_HOLD = 4'h8
	} fsc_bus_e;

	typedef struct packed {
		fsc_bus_e st;
		logic wr;
		logic [7:0] cnt;
		logic [FL_DATA_W-1:0] sync1;
		logic [FL_DATA_W-1:0] sync2;
		logic [FL_DATA_W-1:0] rdata;
		logic done, ce_n, we_n, oe_n, dq_oe;
		logic [FL_ADDR_W-1:0] addr;
		logic [FL_DATA_W-1:0] dq;
	} fsc_bus_s;

	fsc_bus_s s_reg;
	fsc_bus_s s_next;

	// ----------------------------------------
	// Cycle sequencing
	// ----------------------------------------
	always_comb begin
		s_next = s_reg;
		s_next.sync1 = i_dq;
		s_next.sync2 = s_reg.sync1;
		s_next.done = 1'b0;
		unique case (s_reg.st)
			B_IDLE: begin
				if (i_start) begin
					s_next.st = B_SETUP;
					s_next.wr = i_write;
					s_next.addr = i_addr;
					s_next.dq = i_wdata;
					s_next.dq_oe = i_write;
					s_next.ce_n = 1'b0;
				end
			end
			B_SETUP: begin
				s_next.st = B_PULSE;
				s_next.we_n = ~s_reg.wr;
				s_next.oe_n = s_reg.wr;
				// Reads stay open long enough for data to cross the synchroniser
				s_next.cnt = s_reg.wr ? 8'(PULSE) : 8'(PULSE + SYNC_DEPTH);
			end
			B_PULSE: begin
				if (s_reg.cnt > 8'h01) begin
					s_next.cnt = s_reg.cnt - 8'h01;
				end else begin
					s_next.st = B_HOLD;
					s_next.we_n = 1'b1;
					s_next.oe_n = 1'b1;
					if (!s_reg.wr) begin
						s_next.rdata = s_reg.sync2;
					end
				end
			end
			B_HOLD: begin
				s_next.st = B_IDLE;
				s_next.ce_n = 1'b1;
				s_next.dq_oe = 1'b0;
				s_next.done = 1'b1;
			end
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			s_reg <= '{st: B_IDLE, ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, default: '0};
		end else begin
			s_reg <= s_next;
		end
	end

	assign o_done = s_reg.done;
	assign o_rdata = s_reg.rdata;
	assign o_ce_n = s_reg.ce_n;
	assign o_we_n = s_reg.we_n;
	assign o_oe_n = s_reg.oe_n;
	assign o_addr = s_reg.addr;
	assign o_dq = s_reg.dq;
	assign o_dq_oe = s_reg.dq_oe;

endmodule // fsc_bus

//--- hdl/fsc_ctrl.sv
// Host controller for a parallel NOR flash: erase suspend and resume,
// whole-array erase and completion polling, driven from a simple register port.
// Assumes software sets ADDR and WDATA before writing a command to CMD.
//
// Functional notes
// - Suspend code B0H sent only while a sector or block erase runs.
// - Resume sends code 30H to the current address.
// - A new suspend waits at least 200 us after each resume.
// - In bypass, no suspend or resume; bypass must be left first.
// - Whole-array erase: six cycles, last carries 10H at 555H.
// - After completion, wait 1 us and read again for the full bus.
`timescale 1ns/1ps
module fsc_ctrl #(
	parameter int RESUME_GAP = fsc_pkg::RESUME_GAP_CYC,
	parameter int RESUME_W = 17
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [fsc_pkg::SW_ADDR_W-1:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	output logic o_ce_n,
	output logic o_we_n,
	output logic o_oe_n,
	output logic [fsc_pkg::FL_ADDR_W-1:0] o_fl_addr,
	output logic [fsc_pkg::FL_DATA_W-1:0] o_dq,
	output logic o_dq_oe,
	input wire logic [fsc_pkg::FL_DATA_W-1:0] i_dq,
	input wire logic i_ready_busy_n,
	output logic o_wp_n,
	output logic o_fl_rst_n
);
	import fsc_pkg::*;

	typedef enum logic [4:0] {
		S_IDLE = 5'h01,
		S_BUS = 5'h02,
		S_WAITB = 5'h04,
		S_HOLD = 5'h08,
		S_FINAL = 5'h10
	} fsc_state_e;

	typedef struct packed {
		fsc_state_e st;
		logic [3:0] op;
		logic [2:0] step;
		logic first;
		logic final_rd;
		logic [CTRL_W-1:0] ctrl;
		logic [FL_ADDR_W-1:0] addr;
		logic [FL_DATA_W-1:0] wdata;
		logic [FL_DATA_W-1:0] rdata;
		logic [FL_DATA_W-1:0] prev;
		logic [FL_ADDR_W-1:SECT_LSB] susp_sect;
		logic suspended, chip_erasing, abort_seen, refused, sec_toggle;
		logic [15:0] hold;
		logic [RESUME_W-1:0] resume;
		logic rb_s1, rb_s2;
		logic [31:0] rdout;
	} fsc_top_s;

	fsc_top_s s_reg;
	fsc_top_s s_next;
	logic bus_done;
	logic [FL_DATA_W-1:0] bus_rdata;
	logic bus_start;
	logic bus_write;
	logic [FL_ADDR_W-1:0] bus_addr;
	logic [FL_DATA_W-1:0] bus_wdata;
	logic cmd_ok;
	logic [3:0] cmd;

	// ----------------------------------------
	// Pin cycles
	// ----------------------------------------
	fsc_bus u_bus (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_start(bus_start),
		.i_write(bus_write),
		.i_addr(bus_addr),
		.i_wdata(bus_wdata),
		.i_dq(i_dq),
		.o_done(bus_done),
		.o_rdata(bus_rdata),
		.o_ce_n(o_ce_n),
		.o_we_n(o_we_n),
		.o_oe_n(o_oe_n),
		.o_addr(o_fl_addr),
		.o_dq(o_dq),
		.o_dq_oe(o_dq_oe)
	);

	assign bus_start = (s_reg.st == S_BUS);

	// ----------------------------------------
	// Address and data per command step
	// ----------------------------------------
	always_comb begin
		bus_write = 1'b1;
		bus_addr = s_reg.addr;
		bus_wdata = s_reg.wdata;
		unique case (s_reg.op)
			OP_READ, OP_POLL: begin
				bus_write = 1'b0;
			end
			OP_SUSPEND: begin
				bus_wdata = CODE_SUSPEND;
			end
			OP_RESUME: begin
				bus_wdata = CODE_RESUME;
			end
			OP_CHIP_ERASE: begin
				// Unlock, setup, unlock, then the erase code at the unlock address
				bus_addr = (s_reg.step == 3'h1 || s_reg.step == 3'h4) ? ADDR_UNLOCK2 : ADDR_UNLOCK1;
				unique case (s_reg.step)
					3'h0, 3'h3: bus_wdata = CODE_UNLOCK1;
					3'h1, 3'h4: bus_wdata = CODE_UNLOCK2;
					3'h2: bus_wdata = CODE_ERASE_SETUP;
					default: bus_wdata = CODE_CHIP_ERASE;
				endcase
				if (s_reg.step == CHIP_ERASE_LAST) begin
					bus_addr = ADDR_UNLOCK1;
				end
			end
			default: begin
				bus_write = 1'b1;
			end
		endcase
	end

	// ----------------------------------------
	// Command acceptance
	// ----------------------------------------
	assign cmd = i_wdata[3:0];

	always_comb begin
		cmd_ok = 1'b0;
		unique case (cmd)
			OP_READ, OP_POLL: cmd_ok = 1'b1;
			OP_CLR_ABORT: cmd_ok = !s_reg.chip_erasing;
			OP_WRITE: begin
				cmd_ok = !s_reg.chip_erasing &&
					!(s_reg.suspended && s_reg.addr[FL_ADDR_W-1:SECT_LSB] == s_reg.susp_sect);
			end
			OP_SUSPEND: begin
				cmd_ok = s_reg.ctrl[CTRL_SECT_ERASE] && !s_reg.suspended &&
					!s_reg.ctrl[CTRL_BYPASS] &&
					s_reg.resume == '0 && !s_reg.chip_erasing;
			end
			OP_RESUME: begin
				cmd_ok = s_reg.suspended && !s_reg.ctrl[CTRL_BYPASS] &&
					s_reg.rb_s2;
			end
			OP_CHIP_ERASE: begin
				cmd_ok = s_reg.ctrl[CTRL_WP_N] && !s_reg.suspended &&
					!s_reg.chip_erasing && !s_reg.ctrl[CTRL_SECT_ERASE];
			end
			default: cmd_ok = 1'b0;
		endcase
	end

	// ----------------------------------------
	// Main sequencer and registers
	// ----------------------------------------
	always_comb begin
		s_next = s_reg;
		s_next.rb_s1 = i_ready_busy_n;
		s_next.rb_s2 = s_reg.rb_s1;
		if (s_reg.resume != '0) begin
			s_next.resume = s_reg.resume - RESUME_W'(1);
		end
		if (!s_reg.ctrl[CTRL_RST_N]) begin
			s_next.abort_seen = 1'b0;
		end
		if (i_wr) begin
			unique case (i_addr)
				REG_CTRL: s_next.ctrl = i_wdata[CTRL_W-1:0];
				REG_ADDR: s_next.addr = i_wdata[FL_ADDR_W-1:0];
				REG_WDATA: s_next.wdata = i_wdata[FL_DATA_W-1:0];
				REG_CMD: begin
					if (s_reg.st != S_IDLE || !cmd_ok) begin
						s_next.refused = 1'b1;
					end else if (cmd == OP_CLR_ABORT) begin
						s_next.abort_seen = 1'b0;
						s_next.refused = 1'b0;
					end else begin
						s_next.op = cmd;
						s_next.st = S_BUS;
						s_next.step = 3'h0;
						s_next.first = 1'b1;
						s_next.final_rd = 1'b0;
						s_next.refused = 1'b0;
					end
				end
				default: s_next.refused = s_reg.refused;
			endcase
		end
		if (i_rd) begin
			unique case (i_addr)
				REG_CTRL: s_next.rdout = 32'(s_reg.ctrl);
				REG_ADDR: s_next.rdout = 32'(s_reg.addr);
				REG_WDATA: s_next.rdout = 32'(s_reg.wdata);
				REG_RDATA: s_next.rdout = 32'(s_reg.rdata);
				REG_STATUS: s_next.rdout = 32'({s_reg.rdata[BIT_POLLING], s_reg.sec_toggle,
					s_reg.resume != '0, s_reg.rb_s2, s_reg.refused, s_reg.abort_seen,
					s_reg.chip_erasing, s_reg.suspended, s_reg.st != S_IDLE});
				default: s_next.rdout = 32'h0000_0000;
			endcase
		end
		unique case (s_reg.st)
			S_IDLE: begin
			end
			S_BUS: begin
				s_next.st = S_WAITB;
			end
			S_WAITB: begin
				if (bus_done) begin
					s_next.st = S_IDLE;
					unique case (s_reg.op)
						OP_READ: s_next.rdata = bus_rdata;
						OP_SUSPEND: begin
							s_next.suspended = 1'b1;
							s_next.susp_sect = s_reg.addr[FL_ADDR_W-1:SECT_LSB];
							s_next.hold = 16'(SUSPEND_CYC);
							s_next.st = S_HOLD;
						end
						OP_RESUME: begin
							s_next.suspended = 1'b0;
							s_next.resume = RESUME_W'(RESUME_GAP);
						end
						OP_CHIP_ERASE: begin
							if (s_reg.step != CHIP_ERASE_LAST) begin
								s_next.step = s_reg.step + 3'h1;
								s_next.st = S_BUS;
							end else begin
								// Device runs from the sixth strobe edge
								s_next.chip_erasing = 1'b1;
							end
						end
						OP_POLL: begin
							s_next.rdata = bus_rdata;
							s_next.prev = bus_rdata;
							s_next.first = 1'b0;
							if (s_reg.final_rd) begin
								s_next.st = S_IDLE;
							end else if (s_reg.first) begin
								s_next.st = S_BUS;
							end else if (bus_rdata[BIT_PRIMARY_TOGGLE] ==
								s_reg.prev[BIT_PRIMARY_TOGGLE]) begin
								// Toggle stopped: settle, then one more read
								s_next.sec_toggle = bus_rdata[BIT_SECONDARY_TOGGLE] ^
									s_reg.prev[BIT_SECONDARY_TOGGLE];
								s_next.chip_erasing = 1'b0;
								s_next.hold = 16'(SETTLE_CYC);
								s_next.st = S_HOLD;
							end else if (bus_rdata[BIT_BUFFER_ABORT]) begin
								s_next.abort_seen = 1'b1;
								s_next.hold = 16'(ABORT_CYC);
								s_next.st = S_HOLD;
							end else begin
								s_next.sec_toggle = bus_rdata[BIT_SECONDARY_TOGGLE] ^
									s_reg.prev[BIT_SECONDARY_TOGGLE];
								s_next.st = S_BUS;
							end
						end
						default: s_next.st = S_IDLE;
					endcase
				end
			end
			S_HOLD: begin
				if (s_reg.hold > 16'h0001) begin
					s_next.hold = s_reg.hold - 16'h0001;
				end else begin
					s_next.st = S_FINAL;
				end
			end
			S_FINAL: begin
				s_next.st = S_IDLE;
				// Only a completed poll rereads; abort and suspend waits end here
				if (s_reg.op == OP_POLL && !s_reg.abort_seen) begin
					s_next.final_rd = 1'b1;
					s_next.st = S_BUS;
				end
			end
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			s_reg <= '{st: S_IDLE, ctrl: CTRL_RESET, rb_s1: 1'b1, rb_s2: 1'b1, default: '0};
		end else begin
			s_reg <= s_next;
		end
	end

	assign o_rdata = s_reg.rdout;
	assign o_wp_n = s_reg.ctrl[CTRL_WP_N];
	assign o_fl_rst_n = s_reg.ctrl[CTRL_RST_N];

endmodule // fsc_ctrl

//--- dv/fsc_flash_model.sv
// Behavioural NOR flash partner: erase, suspend, resume and status bits.
// Assumes the bench resolves the data bus and the pulled-up ready/busy wire.
`timescale 1ns/1ps
module fsc_flash_model #(
	parameter int ERASE_READS = 5
) (
	input wire logic i_ce_n,
	input wire logic i_we_n,
	input wire logic i_oe_n,
	input wire logic [fsc_pkg::FL_ADDR_W-1:0] i_addr,
	input wire logic [fsc_pkg::FL_DATA_W-1:0] i_dq,
	input wire logic i_wp_n,
	input wire logic i_rst_n,
	input wire logic i_abort,
	output logic [fsc_pkg::FL_DATA_W-1:0] o_dq,
	output logic o_busy_pull
);
	import fsc_pkg::*;
	logic busy = 0, susp = 0, sect = 0, t6 = 0, t2 = 0;
	logic [9:0] ssec = 0;
	int nwr = 0, nrd = 0;
	logic [21:0] ul_a[5] = '{ADDR_UNLOCK1, ADDR_UNLOCK2, ADDR_UNLOCK1, ADDR_UNLOCK1, ADDR_UNLOCK2};
	logic [15:0] ul_d[5] = '{CODE_UNLOCK1, CODE_UNLOCK2, CODE_ERASE_SETUP, CODE_UNLOCK1,
		CODE_UNLOCK2};
	initial o_dq = 16'h0000;
	assign o_busy_pull = busy && !susp;
	always @(posedge i_we_n) if (!i_ce_n) begin
		if (busy && !susp) begin
			if (sect && i_dq == CODE_SUSPEND) susp = 1;
		end else if (susp) begin
			if (i_dq == CODE_RESUME) susp = 0;
		end else begin
			nwr++;
			// A wrong unlock cycle starts the sequence over
			if (nwr < 6 && (i_addr != ul_a[nwr-1] || i_dq != ul_d[nwr-1])) nwr = 0;
			if (nwr == 6 && i_dq == CODE_CHIP_ERASE && i_addr == ADDR_UNLOCK1 && i_wp_n) begin
				busy = 1;
				sect = 0;
				nrd = 0;
			end
			if (nwr == 6 && i_dq == 16'h0050) begin
				busy = 1;
				sect = 1;
				ssec = i_addr[21:12];
				nrd = 0;
			end
			if (nwr >= 6) nwr = 0;
		end
	end
	always @(negedge i_oe_n) if (!i_ce_n) begin
		if (susp && i_addr[21:12] == ssec) begin
			t2 = !t2;
			o_dq = 16'h00C0 | {13'h0, t2, 2'h0};
		end else if (busy && !susp || i_abort) begin
			t6 = !t6;
			t2 = !t2;
			nrd++;
			o_dq = {9'h0, t6, 3'h0, t2, i_abort, 1'b0};
			if (nrd >= ERASE_READS && !i_abort) busy = 0;
		end else o_dq = 16'hFFFF;
	end
	// Released bus shows the inverse, never a stale copy
	always @(posedge i_oe_n) #1 o_dq = ~o_dq;
	always @(negedge i_rst_n) begin
		busy = 0;
		susp = 0;
		nwr = 0;
	end
endmodule // fsc_flash_model

//--- dv/fsc_ctrl_asserts.sv
// Port-level assertions for the flash erase and status controller.
// Assumes one clock domain and the register map of the package.
`timescale 1ns/1ps
module fsc_ctrl_asserts #(
	parameter int RESUME_GAP = 40000
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [fsc_pkg::SW_ADDR_W-1:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic o_ce_n,
	input wire logic o_we_n,
	input wire logic o_oe_n,
	input wire logic [fsc_pkg::FL_ADDR_W-1:0] o_fl_addr,
	input wire logic [fsc_pkg::FL_DATA_W-1:0] o_dq,
	input wire logic o_dq_oe,
	input wire logic o_wp_n
);
	import fsc_pkg::*;
	logic sect_q, byp_q;
	int gap_q;
	// Software view of CTRL and time since the last resume strobe
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			sect_q <= 1'b0;
			byp_q <= 1'b0;
			gap_q <= RESUME_GAP;
		end else begin
			if (i_wr && i_addr == REG_CTRL) begin
				sect_q <= i_wdata[CTRL_SECT_ERASE];
				byp_q <= i_wdata[CTRL_BYPASS];
			end
			if (!o_we_n && o_dq == CODE_RESUME) gap_q <= 0;
			else if (gap_q < RESUME_GAP) gap_q <= gap_q + 1;
		end
	end
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	sequence we_pulse;
		!o_we_n [*8] ##1 o_we_n;
	endsequence
	sequence we_start(logic [15:0] c);
		$fell(o_we_n) && o_dq == c;
	endsequence
	we_width_a: assert property ($fell(o_we_n) |-> we_pulse)
		else $error("write strobe width wrong");
	we_frame_a: assert property (!o_we_n |-> !o_ce_n && o_dq_oe && o_oe_n)
		else $error("write strobe outside a driven select");
	we_hold_a: assert property (!o_we_n && !$past(o_we_n) |-> $stable(o_fl_addr) && $stable(o_dq))
		else $error("address or data moved under write strobe");
	rd_frame_a: assert property (!o_oe_n |-> o_we_n && !o_dq_oe && !o_ce_n)
		else $error("read overlaps a drive");
	susp_gate_a: assert property (we_start(CODE_SUSPEND) |-> sect_q && !byp_q)
		else $error("suspend sent without a sector erase");
	susp_gap_a: assert property (we_start(CODE_SUSPEND) |-> gap_q >= RESUME_GAP)
		else $error("suspend too soon after resume");
	resume_byp_a: assert property (we_start(CODE_RESUME) |-> !byp_q)
		else $error("resume sent in bypass");
	chip_wp_a: assert property (we_start(CODE_CHIP_ERASE) |-> o_wp_n && o_fl_addr == ADDR_UNLOCK1)
		else $error("chip erase code badly placed");
	wp_follow_a: assert property (i_wr && i_addr == REG_CTRL |=> o_wp_n == $past(i_wdata[CTRL_WP_N]))
		else $error("protect pin ignores control");
endmodule // fsc_ctrl_asserts
bind fsc_ctrl fsc_ctrl_asserts #(.RESUME_GAP(RESUME_GAP)) fsc_ctrl_asserts_inst (.i_clk(i_clk),
	.i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .o_ce_n(o_ce_n),
	.o_we_n(o_we_n), .o_oe_n(o_oe_n), .o_fl_addr(o_fl_addr), .o_dq(o_dq), .o_dq_oe(o_dq_oe),
	.o_wp_n(o_wp_n));

//--- dv/fsc_ctrl_test.sv
// Self-checking bench for the flash controller against the flash model.
// Assumes a 200 MHz clock and a shortened resume gap.
`timescale 1ns/1ps
module fsc_ctrl_test;
	import fsc_pkg::*;
	typedef struct {logic [7:0] a; logic [31:0] e; logic [31:0] m;} fsc_chk_s;
	logic i_clk = 0, i_rst_n = 0, i_wr = 0, i_rd = 0, abort_on = 0, rd_d = 0;
	logic [7:0] i_addr = 0;
	logic [31:0] i_wdata = 0, o_rdata;
	logic ce_n, we_n, oe_n, dq_oe, wp_n, fl_rst_n, busy_pull;
	logic [21:0] fl_addr;
	logic [15:0] dq_out, dq_flash;
	logic [21:0] seq_a[6] = '{ADDR_UNLOCK1, ADDR_UNLOCK2, ADDR_UNLOCK1, ADDR_UNLOCK1, ADDR_UNLOCK2,
		22'h007000};
	logic [15:0] seq_d[6] = '{16'h00AA, 16'h0055, 16'h0080, 16'h00AA, 16'h0055, 16'h0050};
	fsc_chk_s chk_q[$];
	fsc_chk_s c;
	int err_total = 0, n_compared = 0;
	always #2.5 i_clk = ~i_clk;
	fsc_ctrl #(.RESUME_GAP(50)) fsc_ctrl_inst (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_ce_n(ce_n),
		.o_we_n(we_n), .o_oe_n(oe_n), .o_fl_addr(fl_addr), .o_dq(dq_out), .o_dq_oe(dq_oe),
		.i_dq(dq_oe ? dq_out : dq_flash), .i_ready_busy_n(!busy_pull), .o_wp_n(wp_n),
		.o_fl_rst_n(fl_rst_n));
	fsc_flash_model fsc_flash_model_inst (.i_ce_n(ce_n), .i_we_n(we_n), .i_oe_n(oe_n),
		.i_addr(fl_addr), .i_dq(dq_out), .i_wp_n(wp_n), .i_rst_n(fl_rst_n), .i_abort(abort_on),
		.o_dq(dq_flash), .o_busy_pull(busy_pull));
	// ----
	// Bus tasks and result monitor
	// ----
	always @(posedge i_clk) begin
		if (rd_d) begin
			c = chk_q.pop_front();
			if (c.m != 0) begin
				n_compared++;
				if ((o_rdata & c.m) !== c.e) begin
					err_total++;
					$display("BAD reg %h exp %h seen %h", c.a, c.e, o_rdata & c.m);
				end
			end
		end
		rd_d <= i_rd;
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		@(posedge i_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		chk_q.push_back('{a, e & m, m});
		@(posedge i_clk);
		i_rd <= 1'b0;
	endtask
	task automatic cmd(input logic [3:0] op);
		int n;
		n = 0;
		wr(REG_CMD, {28'h0, op});
		do begin
			rd(REG_STATUS, 0, 0);
			@(posedge i_clk);
			n++;
		end while (o_rdata[ST_BUSY] !== 1'b0 && n < 3000);
		if (n >= 3000) begin
			err_total++;
			$display("BAD busy exp 0 seen 1");
		end
	endtask
	task automatic fw(input logic [21:0] a, input logic [15:0] d);
		wr(REG_ADDR, {10'h0, a});
		wr(REG_WDATA, {16'h0, d});
		cmd(OP_WRITE);
	endtask
	task automatic give_verdict();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// ----
	// Tests
	// ----
	initial begin
		logic [31:0] r;
		r = $urandom(32'hC5EE);
		repeat (8) @(posedge i_clk);
		i_rst_n <= 1'b1;
		rd(REG_CTRL, {28'h0, CTRL_RESET}, 32'hF);
		rd(8'h20, 0, 32'hFFFFFFFF);
		r = $urandom();
		wr(REG_WDATA, r);
		rd(REG_WDATA, r, 32'hFFFF);
		wr(REG_ADDR, r);
		rd(REG_ADDR, r, 32'h3FFFFF);
		$display("test registers done");
		wr(REG_CTRL, 32'h2);
		cmd(OP_CHIP_ERASE);
		rd(REG_STATUS, 32'h10, 32'h14);
		wr(REG_CTRL, 32'h3);
		cmd(OP_CHIP_ERASE);
		rd(REG_STATUS, 32'h04, 32'h25);
		cmd(OP_WRITE);
		rd(REG_STATUS, 32'h14, 32'h14);
		cmd(OP_POLL);
		rd(REG_STATUS, 32'h120, 32'h124);
		rd(REG_RDATA, 32'hFFFF, 32'hFFFF);
		$display("test chip erase done");
		for (int k = 0; k < 6; k++) fw(seq_a[k], seq_d[k]);
		wr(REG_CTRL, 32'hB);
		cmd(OP_SUSPEND);
		rd(REG_STATUS, 32'h22, 32'h23);
		cmd(OP_READ);
		rd(REG_RDATA, 32'hC0, 32'hC0);
		cmd(OP_POLL);
		rd(REG_STATUS, 32'h182, 32'h183);
		wr(REG_ADDR, 32'h1000);
		cmd(OP_READ);
		rd(REG_RDATA, 32'hFFFF, 32'hFFFF);
		wr(REG_ADDR, 32'h7010);
		cmd(OP_WRITE);
		rd(REG_STATUS, 32'h10, 32'h10);
		wr(REG_CTRL, 32'hF);
		cmd(OP_RESUME);
		rd(REG_STATUS, 32'h12, 32'h12);
		wr(REG_CTRL, 32'hB);
		cmd(OP_RESUME);
		rd(REG_STATUS, 32'h40, 32'h42);
		cmd(OP_SUSPEND);
		rd(REG_STATUS, 32'h10, 32'h12);
		repeat (60) @(posedge i_clk);
		cmd(OP_SUSPEND);
		rd(REG_STATUS, 32'h02, 32'h43);
		cmd(OP_RESUME);
		rd(REG_STATUS, 32'h00, 32'h02);
		wr(REG_CTRL, 32'h3);
		cmd(OP_POLL);
		rd(REG_STATUS, 32'h100, 32'h101);
		$display("test suspend done");
		abort_on <= 1'b1;
		cmd(OP_POLL);
		rd(REG_STATUS, 32'h08, 32'h08);
		abort_on <= 1'b0;
		cmd(OP_CLR_ABORT);
		rd(REG_STATUS, 32'h0, 32'h08);
		abort_on <= 1'b1;
		cmd(OP_POLL);
		rd(REG_STATUS, 32'h08, 32'h08);
		abort_on <= 1'b0;
		wr(REG_CTRL, 32'h1);
		rd(REG_STATUS, 32'h0, 32'h08);
		wr(REG_CTRL, 32'h3);
		$display("test abort done");
		repeat (4) @(posedge i_clk);
		give_verdict();
	end
	initial begin
		repeat (60000) @(posedge i_clk);
		err_total++;
		$display("BAD watchdog exp done seen hang");
		give_verdict();
	end
endmodule // fsc_ctrl_test
